// ==== rtl/dsif_top.sv ====
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
//
// Contract
// - A descriptor decode error sets the decode error flag and halts; only reset clears it.
// - After an error halt, status bit 1 is set only once the engine reports shutdown complete.
// - A finished simple transfer, or a scatter-gather one that meets the threshold count, sets completion flag bit 12.
// - The interrupt follows the completion flag only while control bit 12 is 1.
// - In scatter-gather mode completion is raised only when the threshold count is met.
// - A delay timer timeout sets delay flag bit 13.
// - The interrupt follows the delay flag only while control bit 13 is 1.
// - Any engine error sets error flag bit 14.
// - The interrupt follows the error flag only while control bit 14 is 1.
// - Flags 12 to 14 are sticky and a write of 1 to a bit clears it.
// - Status bits 23 to 16 show the live interrupt threshold counter, read-only.
// - Status bits 31 to 24 show the live interrupt delay timer, read-only.
module dsif_top #(
  parameter int DLY_PRESCALE = dsif_pkg::DLY_PRESCALE
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic        xfer_done_in,
  input  wire logic        sg_mode_in,
  input  wire logic        eng_err_in,
  input  wire logic        sg_dec_err_in,
  input  wire logic        halt_done_in,
  output logic             halt_req_out,
  output logic             soft_rst_out,
  output logic             irq_out
);
  localparam int PSC_W = (DLY_PRESCALE > 1) ? $clog2(DLY_PRESCALE) : 1;

  logic [31:0]                 ctrl_q;
  logic [31:0]                 ctrl_d;
  logic                        soft_rst_q;
  logic                        soft_rst_d;
  logic [31:0]                 rdata_q;
  logic [31:0]                 rdata_d;
  logic                        sgdec_q;
  logic                        sgdec_d;
  logic                        halt_req_q;
  logic                        halt_req_d;
  logic                        halted_q;
  logic                        halted_d;
  logic [7:0]                  thr_cnt_q;
  logic [7:0]                  thr_cnt_d;
  logic [7:0]                  dly_tmr_q;
  logic [7:0]                  dly_tmr_d;
  logic [PSC_W-1:0]            psc_q;
  logic [PSC_W-1:0]            psc_d;
  logic                        wr_ctrl;
  logic                        wr_stat;
  logic [7:0]                  thr_reload;
  logic [7:0]                  thr_new;
  logic [7:0]                  dly_val;
  logic                        tick;
  logic                        pending;
  logic                        cmpl_evt;
  logic                        dly_evt;
  logic                        err_evt;
  logic [dsif_pkg::FLAG_N-1:0] flag_set;
  logic [dsif_pkg::FLAG_N-1:0] flag_clr;
  logic [dsif_pkg::FLAG_N-1:0] flag_q;
  logic [dsif_pkg::FLAG_N-1:0] flag_en;
  logic [31:0]                 stat_view;

  // bus decode and control fields
  assign wr_ctrl    = reg_wr_in && (reg_addr_in == dsif_pkg::CTRL_OFS);
  assign wr_stat    = reg_wr_in && (reg_addr_in == dsif_pkg::STAT_OFS);
  assign thr_new    = reg_wdata_in[dsif_pkg::THR_LSB +: dsif_pkg::FIELD_W];
  assign dly_val    = ctrl_q[dsif_pkg::DLY_LSB +: dsif_pkg::FIELD_W];
  assign thr_reload = (ctrl_q[dsif_pkg::THR_LSB +: dsif_pkg::FIELD_W] == 8'h00) ? 8'h01
                      : ctrl_q[dsif_pkg::THR_LSB +: dsif_pkg::FIELD_W];
  assign flag_en    = ctrl_q[dsif_pkg::FLAG_LSB +: dsif_pkg::FLAG_N];

  // engine events
  assign cmpl_evt = xfer_done_in && (!sg_mode_in || thr_cnt_q <= 8'h01);
  assign err_evt  = eng_err_in || sg_dec_err_in;
  assign tick     = (psc_q == PSC_W'(DLY_PRESCALE - 1));
  assign pending  = sg_mode_in && (thr_cnt_q != thr_reload);
  assign dly_evt  = pending && !xfer_done_in && tick && (dly_val != 8'h00)
                    && ((dly_tmr_q + 8'h01) == dly_val);

  // control register, soft reset pulse and read data
  always_comb begin
    ctrl_d     = ctrl_q;
    soft_rst_d = 1'b0;
    rdata_d    = dsif_pkg::RDATA_IDLE;
    if (soft_rst_q) begin
      ctrl_d = dsif_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_d     = reg_wdata_in & dsif_pkg::CTRL_WMASK;
      soft_rst_d = reg_wdata_in[dsif_pkg::SOFT_RST_BIT];
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        dsif_pkg::CTRL_OFS: rdata_d = ctrl_q;
        dsif_pkg::STAT_OFS: rdata_d = stat_view;
        default:            rdata_d = dsif_pkg::RDATA_IDLE;
      endcase
    end
  end

  // control registers
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      ctrl_q     <= dsif_pkg::CTRL_RST;
      soft_rst_q <= 1'b0;
      rdata_q    <= dsif_pkg::RDATA_IDLE;
    end else begin
      ctrl_q     <= ctrl_d;
      soft_rst_q <= soft_rst_d;
      rdata_q    <= rdata_d;
    end
  end

  // decode error and halt sequencing; status writes cannot clear these, only soft reset does
  always_comb begin
    sgdec_d    = sgdec_q;
    halt_req_d = halt_req_q;
    halted_d   = halted_q;
    if (soft_rst_q) begin
      sgdec_d    = 1'b0;
      halt_req_d = 1'b0;
      halted_d   = 1'b0;
    end else begin
      if (sg_dec_err_in) begin
        sgdec_d = 1'b1;
      end
      if (err_evt) begin
        halt_req_d = 1'b1;
      end
      if (halt_req_q && halt_done_in) begin
        halted_d = 1'b1;
      end
    end
  end

  // halt registers
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      sgdec_q    <= 1'b0;
      halt_req_q <= 1'b0;
      halted_q   <= 1'b0;
    end else begin
      sgdec_q    <= sgdec_d;
      halt_req_q <= halt_req_d;
      halted_q   <= halted_d;
    end
  end

  // threshold counter, delay timer and its prescaler
  always_comb begin
    thr_cnt_d = thr_cnt_q;
    dly_tmr_d = dly_tmr_q;
    psc_d     = tick ? '0 : psc_q + PSC_W'(1);
    if (soft_rst_q) begin
      thr_cnt_d = dsif_pkg::THR_RST;
      dly_tmr_d = dsif_pkg::DLY_RST;
      psc_d     = '0;
    end else if (wr_ctrl) begin
      thr_cnt_d = (thr_new == 8'h00) ? 8'h01 : thr_new;
      dly_tmr_d = dsif_pkg::DLY_RST;
    end else if (xfer_done_in && sg_mode_in) begin
      thr_cnt_d = (thr_cnt_q <= 8'h01) ? thr_reload : thr_cnt_q - 8'h01;
      dly_tmr_d = dsif_pkg::DLY_RST;
    end else if (dly_evt) begin
      thr_cnt_d = thr_reload;
      dly_tmr_d = dsif_pkg::DLY_RST;
    end else if (pending && tick && dly_val != 8'h00) begin
      dly_tmr_d = dly_tmr_q + 8'h01;
    end
  end

  // counter registers
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      thr_cnt_q <= dsif_pkg::THR_RST;
      dly_tmr_q <= dsif_pkg::DLY_RST;
      psc_q     <= '0;
    end else begin
      thr_cnt_q <= thr_cnt_d;
      dly_tmr_q <= dly_tmr_d;
      psc_q     <= psc_d;
    end
  end

  // sticky interrupt flags with write-one clear
  assign flag_set[dsif_pkg::CMPL_IDX] = cmpl_evt;
  assign flag_set[dsif_pkg::DLY_IDX]  = dly_evt;
  assign flag_set[dsif_pkg::ERR_IDX]  = err_evt;
  assign flag_clr = {dsif_pkg::FLAG_N{wr_stat}}
                    & reg_wdata_in[dsif_pkg::FLAG_LSB +: dsif_pkg::FLAG_N];

  genvar gi;
  generate
    for (gi = 0; gi < dsif_pkg::FLAG_N; gi = gi + 1) begin : g_flag
      dsif_flag u_flag (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .soft_rst_in (soft_rst_q),
        .set_in      (flag_set[gi]),
        .clr_in      (flag_clr[gi]),
        .flag_out    (flag_q[gi])
      );
    end
  endgenerate

  // status view with reserved bits at zero
  always_comb begin
    stat_view = 32'h0000_0000;
    stat_view[dsif_pkg::HALT_BIT] = halted_q;
    stat_view[dsif_pkg::SGDEC_BIT] = sgdec_q;
    stat_view[dsif_pkg::FLAG_LSB +: dsif_pkg::FLAG_N] = flag_q;
    stat_view[dsif_pkg::THR_LSB +: dsif_pkg::FIELD_W] = thr_cnt_q;
    stat_view[dsif_pkg::DLY_LSB +: dsif_pkg::FIELD_W] = dly_tmr_q;
  end

  // outputs
  assign irq_out       = |(flag_q & flag_en);
  assign halt_req_out  = halt_req_q;
  assign soft_rst_out  = soft_rst_q;
  assign reg_rdata_out = rdata_q;

  // checks
  sequence s_stat_rd;
    reg_rd_in && reg_addr_in == dsif_pkg::STAT_OFS;
  endsequence

  sequence s_cmpl_clr;
    wr_stat && reg_wdata_in[dsif_pkg::FLAG_LSB] && !cmpl_evt && !soft_rst_q;
  endsequence

  property p_sgdec_set;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      sg_dec_err_in && !soft_rst_q |=> sgdec_q && halt_req_out;
  endproperty
  a_sgdec_set: assert property (p_sgdec_set) else $error("decode error not flagged");

  property p_sgdec_hold;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      sgdec_q && !soft_rst_q |=> sgdec_q;
  endproperty
  a_sgdec_hold: assert property (p_sgdec_hold) else $error("decode error lost");

  property p_halted;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      $rose(halted_q) |-> $past(halt_done_in) && $past(halt_req_q);
  endproperty
  a_halted: assert property (p_halted) else $error("halted set early");

  property p_cmpl_simple;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      xfer_done_in && !sg_mode_in && !soft_rst_q |=> flag_q[dsif_pkg::CMPL_IDX];
  endproperty
  a_cmpl_simple: assert property (p_cmpl_simple) else $error("completion missed");

  property p_sg_thr;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      xfer_done_in && sg_mode_in && thr_cnt_q > 8'h01 && !wr_ctrl && !soft_rst_q
      |=> thr_cnt_q == $past(thr_cnt_q) - 8'h01;
  endproperty
  a_sg_thr: assert property (p_sg_thr) else $error("threshold not counted");

  property p_dly;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      dly_evt && !soft_rst_q |=> flag_q[dsif_pkg::DLY_IDX] && dly_tmr_q == 8'h00;
  endproperty
  a_dly: assert property (p_dly) else $error("delay timeout missed");

  property p_err;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      eng_err_in && !soft_rst_q |=> flag_q[dsif_pkg::ERR_IDX] ##0 halt_req_out;
  endproperty
  a_err: assert property (p_err) else $error("error not flagged");

  property p_irq;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      irq_out == ((flag_q[0] && ctrl_q[12]) || (flag_q[1] && ctrl_q[13])
                  || (flag_q[2] && ctrl_q[14]));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch");

  property p_w1c;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      s_cmpl_clr |=> !flag_q[dsif_pkg::CMPL_IDX];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_stat_rd;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      s_stat_rd |=> reg_rdata_out[23:16] == $past(thr_cnt_q)
                 && reg_rdata_out[31:24] == $past(dly_tmr_q)
                 && !reg_rdata_out[11] && !reg_rdata_out[15];
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status view wrong");
endmodule

// ==== common/dsif_pkg.sv ====
package dsif_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  // field positions in the control and status registers
  localparam int          HALT_BIT      = 1;
  localparam int          SOFT_RST_BIT  = 2;
  localparam int          SGDEC_BIT     = 10;
  localparam int          FLAG_LSB      = 12;
  localparam int          FLAG_N        = 3;
  localparam int          CMPL_IDX      = 0;
  localparam int          DLY_IDX       = 1;
  localparam int          ERR_IDX       = 2;
  localparam int          THR_LSB       = 16;
  localparam int          DLY_LSB       = 24;
  localparam int          FIELD_W       = 8;
  // control write mask and values after reset
  localparam logic [31:0] CTRL_WMASK    = 32'hFFFF_7000;
  localparam logic [31:0] CTRL_RST      = 32'h0001_0000;
  localparam logic [7:0]  THR_RST       = 8'h01;
  localparam logic [7:0]  DLY_RST       = 8'h00;
  localparam logic [31:0] RDATA_IDLE    = 32'h0000_0000;
  // delay timer tick: 1250 ns per timer step at the 10 ns core clock
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          DLY_STEP_NS   = 1250;
  localparam int          DLY_PRESCALE  = DLY_STEP_NS / CLK_PERIOD_NS;
endpackage

// ==== rtl/dsif_flag.sv ====
`timescale 1ns/100ps
// one sticky event flag: set wins over clear, soft reset clears
module dsif_flag (
  input  wire logic core_clk_in,
  input  wire logic rst_b_in,
  input  wire logic soft_rst_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);
  logic flag_q;
  logic flag_d;

  // next value: reset, then set, then write-one clear
  always_comb begin
    if (soft_rst_in) begin
      flag_d = 1'b0;
    end else if (set_in) begin
      flag_d = 1'b1;
    end else if (clr_in) begin
      flag_d = 1'b0;
    end else begin
      flag_d = flag_q;
    end
  end

  // flag register
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;
endmodule

// ==== test/dsif_engine_model.sv ====
`timescale 1ns/100ps
// engine side: reports shutdown complete a fixed time after a halt request
module dsif_engine_model #(
  parameter int STOP_CYCLES = 6
) (
  input  wire logic core_clk_in,
  input  wire logic rst_b_in,
  input  wire logic halt_req_in,
  output logic      halt_done_out
);
  logic [7:0] stop_cnt_q;
  // count drain cycles while a halt is requested, hold done as a level once drained
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || !halt_req_in) begin
      stop_cnt_q <= 8'h00;
    end else if (stop_cnt_q != 8'(STOP_CYCLES)) begin
      stop_cnt_q <= stop_cnt_q + 8'h01;
    end
  end
  assign halt_done_out = (stop_cnt_q == 8'(STOP_CYCLES));
endmodule

// ==== test/dsif_top_tb.sv ====
`timescale 1ns/100ps
module dsif_top_tb;
  logic        core_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [3:0]  ev = 4'h0; // done, eng error, decode error, unused
  logic        sg_mode = 1'b0;
  logic        halt_done, halt_req, soft_rst, irq_out;
  logic [31:0] d;
  int          num_errors = 0;
  int          tests_run = 0;
  // 100 MHz core clock
  always #5 core_clk_in = ~core_clk_in;
  dsif_top #(.DLY_PRESCALE(2)) DUT (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .xfer_done_in(ev[0]), .sg_mode_in(sg_mode),
    .eng_err_in(ev[1]), .sg_dec_err_in(ev[2]), .halt_done_in(halt_done),
    .halt_req_out(halt_req), .soft_rst_out(soft_rst), .irq_out(irq_out));
  dsif_engine_model #(.STOP_CYCLES(6)) engine (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .halt_req_in(halt_req),
    .halt_done_out(halt_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    tests_run++;
    if ((got & msk) !== (exp & msk)) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got & msk, exp & msk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b0;
    // let the register update settle before anything is sampled
    @(negedge core_clk_in);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b0;
    @(negedge core_clk_in);
    d = reg_rdata_out;
    chk(d, exp, msk);
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk_in);
    ev[i] <= 1'b1;
    @(posedge core_clk_in);
    ev[i] <= 1'b0;
    @(negedge core_clk_in);
  endtask
  task automatic irq_chk(input logic exp);
    chk({31'h0, irq_out}, {31'h0, exp}, 32'h0000_0001);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog well beyond the expected hundred or so cycles
  initial begin
    repeat (20000) @(posedge core_clk_in);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    // reset view and unmapped place
    rchk(dsif_pkg::STAT_OFS, 32'h0001_0000, 32'hFFFF_FFFF);
    rchk(dsif_pkg::CTRL_OFS, 32'h0001_0000, 32'hFFFF_FFFF);
    rchk(8'h08, 32'h0, 32'hFFFF_FFFF);
    $display("test reset done");
    // simple completion, enable gating, write-one clear
    pulse(0);
    rchk(dsif_pkg::STAT_OFS, 32'h0001_1000, 32'h00FF_FFFF);
    irq_chk(1'b0);
    wr(dsif_pkg::CTRL_OFS, 32'h0001_1000);
    irq_chk(1'b1);
    wr(dsif_pkg::STAT_OFS, 32'h0000_1000);
    rchk(dsif_pkg::STAT_OFS, 32'h0001_0000, 32'h00FF_FFFF);
    irq_chk(1'b0);
    $display("test completion done");
    // threshold of two in scatter-gather mode
    @(posedge core_clk_in);
    sg_mode <= 1'b1;
    wr(dsif_pkg::CTRL_OFS, 32'h0002_1000);
    pulse(0);
    rchk(dsif_pkg::STAT_OFS, 32'h0001_0000, 32'h00FF_FFFF);
    irq_chk(1'b0);
    pulse(0);
    rchk(dsif_pkg::STAT_OFS, 32'h0002_1000, 32'h00FF_FFFF);
    wr(dsif_pkg::STAT_OFS, 32'h0000_1000);
    $display("test threshold done");
    // delay timeout with one completion pending
    wr(dsif_pkg::CTRL_OFS, 32'h0102_2000);
    pulse(0);
    for (int n = 0; n < 40; n++) begin
      rchk(dsif_pkg::STAT_OFS, 32'h0, 32'h0000_8800);
      if (d[13] === 1'b1) break;
    end
    chk(d, 32'h0002_2000, 32'h00FF_FFFF);
    irq_chk(1'b1);
    wr(dsif_pkg::CTRL_OFS, 32'h0102_0000);
    irq_chk(1'b0);
    @(posedge core_clk_in);
    sg_mode <= 1'b0;
    wr(dsif_pkg::STAT_OFS, 32'h0000_2000);
    $display("test delay done");
    // engine error, halt, then shutdown report
    wr(dsif_pkg::CTRL_OFS, 32'h0001_4000);
    pulse(1);
    chk({31'h0, halt_req}, 32'h1, 32'h1);
    irq_chk(1'b1);
    rchk(dsif_pkg::STAT_OFS, 32'h0001_4000, 32'h00FF_FFFF);
    repeat (8) @(posedge core_clk_in);
    rchk(dsif_pkg::STAT_OFS, 32'h0001_4002, 32'h00FF_FFFF);
    wr(dsif_pkg::STAT_OFS, 32'h0000_4000);
    rchk(dsif_pkg::STAT_OFS, 32'h0001_0002, 32'h00FF_FFFF);
    $display("test error done");
    // decode error survives a status write of all ones, soft reset clears it, reserved bits read zero
    pulse(2);
    wr(dsif_pkg::STAT_OFS, 32'hFFFF_FFFF);
    rchk(dsif_pkg::STAT_OFS, 32'h0001_0402, 32'h00FF_FFFF);
    wr(dsif_pkg::CTRL_OFS, 32'h0000_0004);
    chk({31'h0, soft_rst}, 32'h1, 32'h1);
    repeat (3) @(posedge core_clk_in);
    rchk(dsif_pkg::STAT_OFS, 32'h0001_0000, 32'hFFFF_FFFF);
    rchk(dsif_pkg::CTRL_OFS, 32'h0001_0000, 32'hFFFF_FFFF);
    chk({31'h0, halt_req}, 32'h0, 32'h1);
    $display("test decode error done");
    wrap_up();
  end
endmodule
